// ---- ltxit_csum.sv ----
`timescale 1ns/100ps
// modulo 256 sum of one lane's configuration octets
module ltxit_csum
    import ltxit_pkg::*;
#(
    parameter int NUM_OCTETS = 14
)
(
    input  wire logic [NUM_OCTETS*8-1:0] octets_in,
    output logic      [7:0]              sum_out
);

    ////////////////////////////////////////////////////////////////
    // add the octets, carry beyond bit 7 dropped
    always_comb
    begin
        sum_out = 8'h00;
        for (int i = 0; i < NUM_OCTETS; i++)
        begin
            sum_out = sum_out + octets_in[i*8 +: 8];
        end
    end

endmodule : ltxit_csum

// ---- ltxit_pkg.sv ----
package ltxit_pkg;

    // register byte offsets
    localparam logic [7:0] LTXIT_OFS_CHECKSUMS  = 8'hb4;
    localparam logic [7:0] LTXIT_OFS_FXK_SIZE   = 8'hc0;
    localparam logic [7:0] LTXIT_OFS_TEST_SEL   = 8'hd0;
    localparam logic [7:0] LTXIT_OFS_PATTERN_01 = 8'hd4;
    localparam logic [7:0] LTXIT_OFS_PATTERN_23 = 8'hd8;
    localparam logic [7:0] LTXIT_OFS_PATTERN_45 = 8'hdc;
    localparam logic [7:0] LTXIT_OFS_PATTERN_67 = 8'he0;

    // field positions and widths
    localparam int LTXIT_CSUM_W      = 8;
    localparam int LTXIT_CSUM_LANES  = 4;
    localparam int LTXIT_FXK_W       = 10;
    localparam int LTXIT_FXK_HI_LSB  = 2;
    localparam int LTXIT_TEST_W      = 4;
    localparam int LTXIT_PAT_W       = 16;
    localparam int LTXIT_PAT_NUM     = 8;
    localparam int LTXIT_PAT_REGS    = 4;

    // reset values
    localparam logic [1:0]  LTXIT_FXK_LO_VAL   = 2'h3;
    localparam logic [3:0]  LTXIT_TEST_RESET   = 4'h0;
    localparam logic [15:0] LTXIT_PAT_RESET    = 16'h0000;

    // core-owned test mode codes
    localparam logic [3:0] LTXIT_TM_NORMAL = 4'h0;
    localparam logic [3:0] LTXIT_TM_K285   = 4'h1;
    localparam logic [3:0] LTXIT_TM_D215   = 4'h2;

    // character codes for the core test modes
    localparam logic [7:0] LTXIT_CHAR_K285 = 8'hbc;
    localparam logic [7:0] LTXIT_CHAR_D215 = 8'hb5;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ltxit_req_type;

    // transmit-side test control
    typedef struct packed {
        logic       ext_mode;   // code owned by outside pattern logic
        logic       force_char; // send a constant character
        logic       char_is_k;  // control-character flag
        logic [7:0] char_val;   // constant character value
    } ltxit_test_type;

endpackage : ltxit_pkg

// ---- ltxit_regs.sv ----
`timescale 1ns/100ps
module ltxit_regs
    import ltxit_pkg::*;
#(
    parameter logic [31:0] CSUM_RESET     = 32'h00000000,
    parameter logic [7:0]  FXK_HI_RESET   = 8'h07,
    parameter bit          FXK_RUNTIME_WR = 1'b1,
    parameter int          CFG_OCTETS     = 14
)
(
    input  wire logic                       mclk_in,
    input  wire logic                       resetn_in,
    input  wire logic [7:0]                 addr_in,
    input  wire logic [31:0]                wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    input  wire logic [CFG_OCTETS*8-1:0]    lane_cfg_in,
    input  wire logic [1:0]                 lane_sel_in,
    output logic      [31:0]                rdata_out,
    output logic      [31:0]                ilas_csum_out,
    output logic      [9:0]                 ilas_fxk_out,
    output logic      [3:0]                 test_mode_out,
    output logic      [11:0]                test_ctrl_out,
    output logic      [127:0]               patterns_out,
    output logic      [7:0]                 calc_csum_out
);

    ////////////////////////////////////////////////////////////////
    // behaviour notes
    // - every access finishes in one cycle, the port never waits
    // - read data stand only in the cycle after the read strobe,
    //   then the read register drops back to zero
    // - a read straight after a write sees the new value, because
    //   the write lands at the edge that samples its strobe
    // - link-side copies trail the registers by one cycle, so the
    //   sequence builder never sees a word while it is written
    // - the checksum helper is advisory: nothing loads its sum into
    //   the checksum register, software writes it back if wanted
    // - where run-time change is absent the size register keeps its
    //   generation value and writes to it are dropped
    // - the two low size bits are wired to ones, so the stored
    //   product minus one always ends in binary 11
    // - selector codes with the top bit set are only handed on;
    //   checkerboard, ramp and random sources live outside
    // - reserved bits are never stored, so they read as zero and
    //   writes to them vanish without side effects
    // - unmapped offsets decode to no register at all: their writes
    //   are ignored and their reads return zero
    // - a pattern pair register holds two samples, the even one in
    //   the low half and the odd one in the high half
    // - the selector copy and the decoded control word change in the
    //   same cycle, so the link layer never sees them disagree

    ////////////////////////////////////////////////////////////////
    // request bundle
    ltxit_req_type req;                 // current request
    assign req = '{addr: addr_in, wdata: wdata_in,
                   wr: wr_in, rd: rd_in};

    ////////////////////////////////////////////////////////////////
    // local short names for package field positions and widths,
    // kept short so slices below fit on one line
    localparam int CW  = LTXIT_CSUM_W;     // one lane checksum byte
    localparam int NL  = LTXIT_CSUM_LANES; // lanes held in one word
    localparam int FHI = LTXIT_FXK_W - 1;  // top bit of size field
    localparam int FLO = LTXIT_FXK_HI_LSB; // lowest writable size bit
    localparam int TW  = LTXIT_TEST_W;     // selector width
    localparam int PW  = LTXIT_PAT_W;      // one user sample pattern
    localparam int PN  = LTXIT_PAT_NUM;    // user sample patterns

    ////////////////////////////////////////////////////////////////
    // address decode
    logic hit_csum;                     // checksum register
    logic hit_fxk;                      // size register
    logic hit_test;                     // test selector
    logic [LTXIT_PAT_REGS-1:0] hit_pat; // pattern pair registers
    assign hit_csum   = req.addr == LTXIT_OFS_CHECKSUMS;
    assign hit_fxk    = req.addr == LTXIT_OFS_FXK_SIZE;
    assign hit_test   = req.addr == LTXIT_OFS_TEST_SEL;
    assign hit_pat[0] = req.addr == LTXIT_OFS_PATTERN_01;
    assign hit_pat[1] = req.addr == LTXIT_OFS_PATTERN_23;
    assign hit_pat[2] = req.addr == LTXIT_OFS_PATTERN_45;
    assign hit_pat[3] = req.addr == LTXIT_OFS_PATTERN_67;

    ////////////////////////////////////////////////////////////////
    // write enables, one named strobe per register so that every
    // storage process below stays a plain load
    // a write to an unmapped offset raises none of them
    logic                      wr_csum;   // checksum register write
    logic                      wr_test;   // selector write
    logic [LTXIT_PAT_REGS-1:0] wr_pat;    // pattern pair writes
    assign wr_csum = req.wr && hit_csum;
    assign wr_test = req.wr && hit_test;
    assign wr_pat  = {LTXIT_PAT_REGS{req.wr}} & hit_pat;

    ////////////////////////////////////////////////////////////////
    // storage
    // every stored field is a flip-flop with an asynchronous reset;
    // apart from rdata_q, no field here is cleared by hardware, only by software
    logic [31:0] csum_word;               // lanes 7..4 checksums
    logic [7:0]  fxk_hi_q;                // size bits 9:2
    logic [3:0]  test_q;                  // test selector
    logic [31:0] pat_q [LTXIT_PAT_REGS];  // pattern pairs
    logic [PW-1:0] user_sample_pattern [PN];       // one per sample
    logic [31:0]   rd_pat_term [LTXIT_PAT_REGS];   // pair read terms
    logic [31:0]   rd_pat_or   [LTXIT_PAT_REGS+1]; // running or
    logic [31:0] rdata_q;                 // read data register
    logic [31:0] rdata_d;                 // read data next
    logic [11:0] test_ctrl_q;             // decoded test control
    logic [7:0]  calc_q;                  // computed checksum

    ////////////////////////////////////////////////////////////////
    // checksum registers, one byte per lane; the reset value comes
    // from the generation parameter so the first alignment sequence
    // carries usable checksums before software touches anything
    // a write replaces all four lanes at once
    logic [CW-1:0] lane_csum_q [NL];      // lane 4 at index 0
    genvar c;
    generate
        for (c = 0; c < NL; c++)
        begin : gen_csum
            always_ff @(posedge mclk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    lane_csum_q[c] <= CSUM_RESET[CW*c +: CW];
                else if (wr_csum)
                    lane_csum_q[c] <= req.wdata[CW*c +: CW];
            end
        end
    endgenerate

    // named lane views, lane 4 in the lowest byte
    logic [CW-1:0] lane4_checksum;        // bits 7:0
    logic [CW-1:0] lane5_checksum;        // bits 15:8
    logic [CW-1:0] lane6_checksum;        // bits 23:16
    logic [CW-1:0] lane7_checksum;        // bits 31:24
    assign lane4_checksum = lane_csum_q[0];
    assign lane5_checksum = lane_csum_q[1];
    assign lane6_checksum = lane_csum_q[2];
    assign lane7_checksum = lane_csum_q[3];
    assign csum_word = {lane7_checksum, lane6_checksum,
                        lane5_checksum, lane4_checksum};

    ////////////////////////////////////////////////////////////////
    // size upper bits, writable only where run-time change exists
    // a family without run-time change builds with FXK_RUNTIME_WR
    // at zero, which turns the field into a read-only constant
    // only bits 9:2 are stored; bits 1:0 are wired in the views
    logic fxk_wr_en;                      // size write allowed
    assign fxk_wr_en = req.wr && hit_fxk && FXK_RUNTIME_WR;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            fxk_hi_q <= FXK_HI_RESET;
        else if (fxk_wr_en)
            fxk_hi_q <= req.wdata[FHI:FLO];
    end

    ////////////////////////////////////////////////////////////////
    // test selector, only low four bits kept
    // the upper bits of a selector write are dropped on purpose
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            test_q <= LTXIT_TEST_RESET;
        else if (wr_test)
            test_q <= req.wdata[TW-1:0];
    end

    ////////////////////////////////////////////////////////////////
    // user pattern pairs, one per register
    // each pair register is loaded whole; there is no byte enable
    genvar g;
    generate
        for (g = 0; g < LTXIT_PAT_REGS; g++)
        begin : gen_pat
            always_ff @(posedge mclk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                    pat_q[g] <= {LTXIT_PAT_RESET, LTXIT_PAT_RESET};
                else if (wr_pat[g])
                    pat_q[g] <= req.wdata;
            end
            // low half is even sample, high half odd sample
            assign user_sample_pattern[2*g]     = pat_q[g][PW-1:0];
            assign user_sample_pattern[2*g + 1] = pat_q[g][2*PW-1:PW];
            // read term of this pair, chained into a running or
            assign rd_pat_term[g] = hit_pat[g] ? pat_q[g] : 32'h00000000;
            assign rd_pat_or[g+1] = rd_pat_or[g] | rd_pat_term[g];
        end
    endgenerate

    // samples side by side toward the link layer, sample n at 16n
    genvar s;
    generate
        for (s = 0; s < PN; s++)
        begin : gen_sample
            assign patterns_out[PW*s +: PW] = user_sample_pattern[s];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // read mux, unmapped reads and reserved bits give zero
    // bits 1:0 of the size view are wired ones, never stored
    logic [31:0] fxk_word;                // size register view
    logic [31:0] test_word;               // selector view
    assign fxk_word  = {22'h000000, fxk_hi_q, LTXIT_FXK_LO_VAL};
    assign test_word = {28'h0000000, test_q};

    // per-register read terms, zero unless that register is addressed
    logic [31:0] rd_csum_term;            // checksum term
    logic [31:0] rd_fxk_term;             // size term
    logic [31:0] rd_test_term;            // selector term
    assign rd_csum_term = hit_csum ? csum_word : 32'h00000000;
    assign rd_fxk_term  = hit_fxk  ? fxk_word  : 32'h00000000;
    assign rd_test_term = hit_test ? test_word : 32'h00000000;
    assign rd_pat_or[0] = 32'h00000000;

    // offsets never overlap, so an or of the terms is the mux;
    // an unmapped offset leaves every term at zero
    assign rdata_d = rd_csum_term | rd_fxk_term | rd_test_term
                   | rd_pat_or[LTXIT_PAT_REGS];

    // data valid only in the cycle after the read strobe
    // zero at other times, so stale data is never seen as a read
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdata_q <= 32'h00000000;
        else if (req.rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////
    // test mode decode toward the link layer
    // the top selector bit hands the code to outside pattern logic
    logic test_is_ext;                    // code owned outside
    assign test_is_ext = test_q[TW-1];
    ltxit_test_type test_d;               // decoded selector
    // codes 1 and 2 force a fixed character; every other code sends
    // normal traffic as far as this core is concerned
    always_comb
    begin
        test_d = '0;
        test_d.ext_mode = test_is_ext;
        unique case (test_q)
            LTXIT_TM_K285:
            begin
                test_d.force_char = 1'b1;
                test_d.char_is_k  = 1'b1;
                test_d.char_val   = LTXIT_CHAR_K285;
            end
            LTXIT_TM_D215:
            begin
                test_d.force_char = 1'b1;
                test_d.char_val   = LTXIT_CHAR_D215;
            end
            default:
            begin
                test_d.force_char = 1'b0; // normal traffic
            end
        endcase
    end

    // registered so the link layer sees one clean change per write;
    // the spare top bit of the control word stays zero
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            test_ctrl_q <= 12'h000;
        else
            test_ctrl_q <= {1'b0, test_d};
    end

    ////////////////////////////////////////////////////////////////
    // helper checksum of one lane's octets for software
    logic [7:0] calc_d;                   // adder result
    ltxit_csum #(
        .NUM_OCTETS (CFG_OCTETS)
    ) u_csum (
        .octets_in  (lane_cfg_in),
        .sum_out    (calc_d)
    );

    // one register stage keeps the adder chain off the output pin
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            calc_q <= 8'h00;
        else
            calc_q <= calc_d;
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs to the alignment sequence builder
    // copies change one cycle after a write, all fields together
    logic [31:0] csum_out_q;              // checksum copy
    logic [9:0]  fxk_out_q;               // size copy
    logic [3:0]  mode_out_q;              // selector copy
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            csum_out_q <= 32'h00000000;
            fxk_out_q  <= 10'h000;
            mode_out_q <= LTXIT_TEST_RESET;
        end
        else
        begin
            csum_out_q <= csum_word;
            fxk_out_q  <= {fxk_hi_q, LTXIT_FXK_LO_VAL};
            mode_out_q <= test_q;
        end
    end

    assign rdata_out     = rdata_q;
    assign ilas_csum_out = csum_out_q;
    assign ilas_fxk_out  = fxk_out_q;
    assign test_mode_out = mode_out_q;
    assign test_ctrl_out = test_ctrl_q;
    assign calc_csum_out = calc_q;

    // lane_sel_in selects nothing here; reserved for wider builds
    logic unused_sel;
    assign unused_sel = ^lane_sel_in;

endmodule : ltxit_regs

// ---- ltxit_regs_checker.sv ----
`timescale 1ns/100ps
// port-level checks on the transmit test register slice
module ltxit_regs_checker
    import ltxit_pkg::*;
(
    input wire logic         mclk_in,
    input wire logic         resetn_in,
    input wire logic [7:0]   addr_in,
    input wire logic [31:0]  wdata_in,
    input wire logic         wr_in,
    input wire logic         rd_in,
    input wire logic [31:0]  rdata_out,
    input wire logic [31:0]  ilas_csum_out,
    input wire logic [9:0]   ilas_fxk_out,
    input wire logic [3:0]   test_mode_out,
    input wire logic [11:0]  test_ctrl_out,
    input wire logic [127:0] patterns_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////////////
    // access steps
    sequence s_size_rd;
        rd_in && addr_in == LTXIT_OFS_FXK_SIZE;
    endsequence
    sequence s_test_rd;
        rd_in && addr_in == LTXIT_OFS_TEST_SEL;
    endsequence
    sequence s_csum_wr;
        wr_in && addr_in == LTXIT_OFS_CHECKSUMS;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_size_fmt: assert property (
        s_size_rd |=> rdata_out[31:10] == 22'h0 && rdata_out[1:0] == 2'h3)
        else $error("size read format wrong");
    chk_test_rsvd: assert property (
        s_test_rd |=> rdata_out[31:4] == 28'h0)
        else $error("test select reserved bits set");
    chk_fxk_low: assert property (
        $past(resetn_in) |-> ilas_fxk_out[1:0] == 2'h3)
        else $error("size low bits not ones");
    chk_csum_copy: assert property (
        s_csum_wr |-> ##2 ilas_csum_out == $past(wdata_in, 2))
        else $error("checksum output not updated");
    chk_pat_write: assert property (
        wr_in && addr_in == LTXIT_OFS_PATTERN_01
        |=> patterns_out[31:0] == $past(wdata_in))
        else $error("pattern pair not written");
    chk_k285_char: assert property (
        test_mode_out == LTXIT_TM_K285 && $stable(test_mode_out)
        |-> test_ctrl_out[7:0] == LTXIT_CHAR_K285)
        else $error("wrong character for code one");
    chk_d215_char: assert property (
        test_mode_out == LTXIT_TM_D215 && $stable(test_mode_out)
        |-> test_ctrl_out[7:0] == LTXIT_CHAR_D215)
        else $error("wrong character for code two");
    chk_normal_quiet: assert property (
        test_mode_out == LTXIT_TM_NORMAL && $stable(test_mode_out)
        |-> test_ctrl_out == 12'h000)
        else $error("test control active in normal mode");
endmodule : ltxit_regs_checker

bind ltxit_regs ltxit_regs_checker u_ltxit_regs_checker (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ilas_csum_out(ilas_csum_out),
    .ilas_fxk_out(ilas_fxk_out), .test_mode_out(test_mode_out),
    .test_ctrl_out(test_ctrl_out), .patterns_out(patterns_out));

// ---- test_ltxit_regs.sv ----
`timescale 1ns/100ps
module test_ltxit_regs;
    import ltxit_pkg::*;
    localparam logic [31:0] CSUM_INIT = 32'h44332211; // arbitrary
    localparam logic [7:0]  FXK_INIT  = 8'h1f;
    logic         mclk_in;
    logic         resetn_in;
    logic [7:0]   addr_in;
    logic [31:0]  wdata_in;
    logic         wr_in;
    logic         rd_in;
    logic [111:0] lane_cfg_in;
    logic [31:0]  rdata_out;
    logic [31:0]  ilas_csum_out;
    logic [9:0]   ilas_fxk_out;
    logic [3:0]   test_mode_out;
    logic [11:0]  test_ctrl_out;
    logic [127:0] patterns_out;
    logic [7:0]   calc_csum_out;
    int           err_total = 0;
    int           n_checks  = 0;

    ltxit_regs #(.CSUM_RESET(CSUM_INIT), .FXK_HI_RESET(FXK_INIT),
        .FXK_RUNTIME_WR(1'b1), .CFG_OCTETS(14)) u_ltxit_regs (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .lane_cfg_in(lane_cfg_in), .lane_sel_in(2'h0),
        .rdata_out(rdata_out), .ilas_csum_out(ilas_csum_out),
        .ilas_fxk_out(ilas_fxk_out), .test_mode_out(test_mode_out),
        .test_ctrl_out(test_ctrl_out), .patterns_out(patterns_out),
        .calc_csum_out(calc_csum_out));
    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock and a hang guard
    initial
    begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial
    begin
        #50000;
        err_total++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    // read data is looked at in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask : rd
    function automatic logic [31:0] pat(input int i);
        return {16'(16'h1111 * (2 * i + 1)), 16'(16'h1111 * (2 * i))};
    endfunction : pat
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [3:0]   codes [6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha};
        logic [11:0]  ctrls [6] = '{12'h000, {4'h3, LTXIT_CHAR_K285},
            {4'h2, LTXIT_CHAR_D215}, 12'h400, 12'h400, 12'h400};
        logic [111:0] cfg;
        logic [7:0]   s;
        {resetn_in, addr_in, wdata_in, wr_in, rd_in} = '0;
        lane_cfg_in = '0;
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        // reset values
        rd(LTXIT_OFS_CHECKSUMS, CSUM_INIT);
        rd(LTXIT_OFS_FXK_SIZE, {22'h0, FXK_INIT, 2'h3});
        rd(LTXIT_OFS_TEST_SEL, 32'h0);
        for (int i = 0; i < 4; i++)
            rd(LTXIT_OFS_PATTERN_01 + 8'(4 * i), 32'h0);
        chk(ilas_csum_out, CSUM_INIT);
        chk({22'h0, ilas_fxk_out}, {22'h0, FXK_INIT, 2'h3});
        $display("test reset done");
        // writes, reserved bits and field slicing
        wr(LTXIT_OFS_CHECKSUMS, 32'ha5c33c5a);
        rd(LTXIT_OFS_CHECKSUMS, 32'ha5c33c5a);
        chk(ilas_csum_out, 32'ha5c33c5a);
        wr(LTXIT_OFS_FXK_SIZE, 32'hffffff00);
        rd(LTXIT_OFS_FXK_SIZE, 32'h00000303);
        chk({22'h0, ilas_fxk_out}, 32'h00000303);
        for (int i = 0; i < 4; i++)
            wr(LTXIT_OFS_PATTERN_01 + 8'(4 * i), pat(i));
        for (int i = 0; i < 4; i++)
        begin
            rd(LTXIT_OFS_PATTERN_01 + 8'(4 * i), pat(i));
            chk(patterns_out[32 * i +: 32], pat(i));
        end
        // unmapped places hold nothing
        wr(8'h10, 32'hffffffff);
        wr(8'he4, 32'hffffffff);
        rd(8'he4, 32'h0);
        rd(8'h10, 32'h0);
        rd(LTXIT_OFS_PATTERN_01, pat(0));
        $display("test access done");
        // every documented test code
        for (int j = 0; j < 6; j++)
        begin
            wr(LTXIT_OFS_TEST_SEL, {28'hfffffff, codes[j]});
            rd(LTXIT_OFS_TEST_SEL, {28'h0, codes[j]});
            chk({28'h0, test_mode_out}, {28'h0, codes[j]});
            chk({20'h0, test_ctrl_out}, {20'h0, ctrls[j]});
        end
        $display("test modes done");
        // checksum helper wraps modulo 256
        s = 8'h00;
        for (int k = 0; k < 14; k++)
        begin
            cfg[8 * k +: 8] = 8'hf0 + 8'(k);
            s = s + cfg[8 * k +: 8];
        end
        @(posedge mclk_in);
        lane_cfg_in <= cfg;
        repeat (3) @(posedge mclk_in);
        #1 chk({24'h0, calc_csum_out}, {24'h0, s});
        $display("test checksum done");
        // second reset restores defaults
        @(posedge mclk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        resetn_in <= 1'b1;
        rd(LTXIT_OFS_TEST_SEL, 32'h0);
        rd(LTXIT_OFS_PATTERN_67, 32'h0);
        rd(LTXIT_OFS_CHECKSUMS, CSUM_INIT);
        $display("test rereset done");
        conclude();
    end
endmodule : test_ltxit_regs
